// >>> design/adcrc_clk_div.v
// Converter clock prescaler: one tick per converter clock period
`default_nettype none
`include "adcrc_map.vh"

module adcrc_clk_div (
  input wire I_CLK,
  input wire I_RESET,
  input wire i_restart,
  input wire [4:0] i_divider,
  output reg o_tick
);

  reg [6:0] count;
  wire [6:0] period;

  // ============================================================
  // Period select: zero divider means the slowest rate
  assign period = (i_divider == 5'h00) ? `ADCRC_DIV_ZERO_PERIOD : {1'b0, i_divider, 1'b0};

  always @(posedge I_CLK) begin
    if (I_RESET || i_restart) begin
      count <= 7'h00;
      o_tick <= 1'b0;
    end else if (count >= period - 7'h01) begin
      // Greater-or-equal keeps a divider change mid-period from running away
      count <= 7'h00;
      o_tick <= 1'b1;
    end else begin
      count <= count + 7'h01;
      o_tick <= 1'b0;
    end
  end

endmodule // adcrc_clk_div
`default_nettype wire

// >>> design/adcrc_map.vh
// Register offsets, field positions, reset values and timing counts of the ADC control block
`ifndef ADCRC_MAP_VH
`define ADCRC_MAP_VH

// ============================================================
// Register offsets
`define ADCRC_OFF_CLOCK_DIVIDER 8'hf2
`define ADCRC_OFF_CONTROL 8'hf3
`define ADCRC_OFF_RESULT_LOW 8'hf4
`define ADCRC_OFF_RESULT_HIGH 8'hf5
`define ADCRC_OFF_PIN_SELECT 8'hf6
`define ADCRC_OFF_IRQ_STATUS 8'hf7
`define ADCRC_OFF_IRQ_MASK 8'hf8

// ============================================================
// Control register fields
`define ADCRC_CTL_QUIET 6
`define ADCRC_CTL_ON 5
`define ADCRC_CTL_DONE 4
`define ADCRC_CTL_GO 3
`define ADCRC_CTL_SEL_HI 2
`define ADCRC_CTL_SEL_LO 0

// Interrupt status and mask fields
`define ADCRC_IRQ_DONE 0
`define ADCRC_IRQ_REFUSED 1
`define ADCRC_IRQ_BITS 2

// ============================================================
// Reset values
`define ADCRC_RST_BYTE 8'h00
`define ADCRC_RST_DIVIDER 5'h00
`define ADCRC_RST_RESULT 10'h000
`define ADCRC_RST_IRQ 2'h0

// ============================================================
// Timing counts
`define ADCRC_DIV_ZERO_PERIOD 7'h40
`define ADCRC_CONV_PERIODS 4'hb
`define ADCRC_LAST_PERIOD 4'ha

`endif

// >>> design/adcrc_top.v
// ADC register control: registers, conversion sequencer, interrupt
// ============================================================
`default_nettype none
`include "adcrc_map.vh"

module adcrc_top (
  input wire I_CLK,
  input wire I_RESET,
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  input wire [9:0] I_CORE_RESULT,
  output reg [7:0] O_PIN_ANALOG,
  output reg [2:0] O_CHANNEL,
  output reg O_CONVERTER_ON,
  output reg O_SAMPLE_HOLD,
  output reg O_CONVERTING,
  output reg O_QUIET_ACTIVE,
  output reg O_IRQ
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg [1:0] state;
  reg [3:0] period_cnt;
  reg [4:0] divider_value;
  reg quiet_convert;
  reg converter_on;
  reg conversion_done_flag;
  reg convert_go;
  reg [2:0] input_channel_sel;
  reg [7:0] pin_analog_bits;
  reg [9:0] result;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg start_pulse;
  reg done_event;
  reg refused_event;
  reg abort;
  wire tick;

  // Decoder for the write path; the read path decodes I_ADDR in its own case
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire wr_div = I_WR && hit(I_ADDR, `ADCRC_OFF_CLOCK_DIVIDER);
  wire wr_ctl = I_WR && hit(I_ADDR, `ADCRC_OFF_CONTROL);
  wire wr_pin = I_WR && hit(I_ADDR, `ADCRC_OFF_PIN_SELECT);
  wire wr_sts = I_WR && hit(I_ADDR, `ADCRC_OFF_IRQ_STATUS);
  wire wr_msk = I_WR && hit(I_ADDR, `ADCRC_OFF_IRQ_MASK);
  wire [2:0] wr_sel = I_WDATA[`ADCRC_CTL_SEL_HI:`ADCRC_CTL_SEL_LO];

  // ============================================================
  // Converter clock
  adcrc_clk_div adcrc_clk_div_i (
    .I_CLK(I_CLK),
    .I_RESET(I_RESET),
    .i_restart(start_pulse),
    .i_divider(divider_value),
    .o_tick(tick)
  );

  // ============================================================
  // Start decision; a channel not configured as analog refuses the start and raises the refused status
  always @* begin
    start_pulse = 1'b0;
    refused_event = 1'b0;
    if (wr_ctl && I_WDATA[`ADCRC_CTL_GO] && state == ST_IDLE) begin
      if (I_WDATA[`ADCRC_CTL_ON] && pin_analog_bits[wr_sel]) begin
        start_pulse = 1'b1;
      end else begin
        refused_event = 1'b1;
      end
    end
  end

  // Clearing converter_on mid-conversion abandons it without a result
  always @* begin
    abort = (state != ST_IDLE) && wr_ctl && !I_WDATA[`ADCRC_CTL_ON];
    done_event = (state == ST_CONVERT) && tick && (period_cnt == `ADCRC_LAST_PERIOD) && !abort;
  end

  // ============================================================
  // Conversion sequencer
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      period_cnt <= 4'h0;
      result <= `ADCRC_RST_RESULT;
      O_CHANNEL <= 3'h0;
    end else if (abort) begin
      state <= ST_IDLE;
      period_cnt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_pulse) begin
            state <= ST_SAMPLE;
            period_cnt <= 4'h0;
            O_CHANNEL <= wr_sel;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            state <= ST_CONVERT;
            period_cnt <= 4'h1;
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            if (period_cnt == `ADCRC_LAST_PERIOD) begin
              state <= ST_IDLE;
              period_cnt <= 4'h0;
              result <= I_CORE_RESULT;
            end else begin
              period_cnt <= period_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          period_cnt <= 4'h0;
        end
      endcase
    end
  end

  // ============================================================
  // Software registers
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      divider_value <= `ADCRC_RST_DIVIDER;
      quiet_convert <= 1'b0;
      converter_on <= 1'b0;
      conversion_done_flag <= 1'b0;
      convert_go <= 1'b0;
      input_channel_sel <= 3'h0;
      pin_analog_bits <= `ADCRC_RST_BYTE;
      irq_status <= `ADCRC_RST_IRQ;
      irq_mask <= `ADCRC_RST_IRQ;
    end else begin
      // Reserved prescaler bits are not stored
      if (wr_div) begin
        divider_value <= I_WDATA[4:0];
      end
      if (wr_pin) begin
        pin_analog_bits <= I_WDATA;
      end
      if (wr_ctl) begin
        quiet_convert <= I_WDATA[`ADCRC_CTL_QUIET];
        converter_on <= I_WDATA[`ADCRC_CTL_ON];
        input_channel_sel <= wr_sel;
      end
      // Go bit is owned by hardware once set
      if (start_pulse) begin
        convert_go <= 1'b1;
      end else if (done_event || abort) begin
        convert_go <= 1'b0;
      end
      // Done flag: set wins over a software clear in the same cycle
      if (done_event) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_ctl && !I_WDATA[`ADCRC_CTL_DONE]) begin
        conversion_done_flag <= 1'b0;
      end
      if (wr_msk) begin
        irq_mask <= I_WDATA[`ADCRC_IRQ_BITS-1:0];
      end
      irq_status[`ADCRC_IRQ_DONE] <= done_event ||
        (irq_status[`ADCRC_IRQ_DONE] && !(wr_sts && I_WDATA[`ADCRC_IRQ_DONE]));
      irq_status[`ADCRC_IRQ_REFUSED] <= refused_event ||
        (irq_status[`ADCRC_IRQ_REFUSED] && !(wr_sts && I_WDATA[`ADCRC_IRQ_REFUSED]));
    end
  end

  // ============================================================
  // Read path; result writes fall through to no register at all
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      O_RDATA <= `ADCRC_RST_BYTE;
    end else if (I_RD) begin
      case (I_ADDR)
        `ADCRC_OFF_CLOCK_DIVIDER: O_RDATA <= {3'h0, divider_value};
        `ADCRC_OFF_CONTROL: O_RDATA <= {1'b0, quiet_convert, converter_on,
          conversion_done_flag, convert_go, input_channel_sel};
        `ADCRC_OFF_RESULT_LOW: O_RDATA <= {6'h00, result[1:0]};
        `ADCRC_OFF_RESULT_HIGH: O_RDATA <= result[9:2];
        `ADCRC_OFF_PIN_SELECT: O_RDATA <= pin_analog_bits;
        `ADCRC_OFF_IRQ_STATUS: O_RDATA <= {6'h00, irq_status};
        `ADCRC_OFF_IRQ_MASK: O_RDATA <= {6'h00, irq_mask};
        default: O_RDATA <= `ADCRC_RST_BYTE;
      endcase
    end else begin
      O_RDATA <= `ADCRC_RST_BYTE;
    end
  end

  // ============================================================
  // Outputs to the analog core and interrupt controller
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      O_PIN_ANALOG <= `ADCRC_RST_BYTE;
      O_CONVERTER_ON <= 1'b0;
      O_SAMPLE_HOLD <= 1'b0;
      O_CONVERTING <= 1'b0;
      O_QUIET_ACTIVE <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_PIN_ANALOG <= pin_analog_bits;
      O_CONVERTER_ON <= converter_on;
      O_SAMPLE_HOLD <= (state == ST_SAMPLE);
      O_CONVERTING <= (state != ST_IDLE);
      // Quiet mode only asks for low noise while a conversion runs
      O_QUIET_ACTIVE <= quiet_convert && (state != ST_IDLE);
      O_IRQ <= |(irq_status & irq_mask);
    end
  end

endmodule // adcrc_top
`default_nettype wire

// >>> dv/adc_register_control_tb.sv
// Self-checking bench for the ADC register control block
`default_nettype none
module adc_register_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  wire [7:0] rdata, pin;
  wire [9:0] core;
  wire [2:0] chan;
  wire on, sh, conv, quiet, irq;
  int err_count = 0;
  int samples_checked = 0;
  int n, m, base, q;
  logic [7:0] c;
  logic [9:0] res;
  always #2.5 clk = ~clk;
  adcrc_top adcrc_top_i (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(we), .I_RD(re), .O_RDATA(rdata), .I_CORE_RESULT(core), .O_PIN_ANALOG(pin),
    .O_CHANNEL(chan), .O_CONVERTER_ON(on), .O_SAMPLE_HOLD(sh), .O_CONVERTING(conv),
    .O_QUIET_ACTIVE(quiet), .O_IRQ(irq));
  adcrc_core_model adcrc_core_model_i (.I_CLK(clk), .i_channel(chan), .i_converting(conv),
    .o_result(core));
  // ============================================================
  // Bus tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string w);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s %h/%h", $time, w, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Strobe drops before the next call so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, e, "read");
    @(posedge clk);
  endtask
  // Sample-hold and quiet cycles are counted beside the busy cycles of one conversion
  task automatic run(input logic [7:0] v, output int cnt, output int qcnt);
    int k;
    int hcnt;
    cnt = 0;
    qcnt = 0;
    hcnt = 0;
    wr(8'hf3, v);
    for (k = 0; k < 3000 && !(cnt > 0 && conv === 1'b0); k++) begin
      @(posedge clk);
      #1;
      if (conv === 1'b1) cnt++;
      if (quiet === 1'b1) qcnt++;
      if (sh === 1'b1) hcnt++;
    end
    @(posedge clk);
    chk({7'h0, hcnt * 11 == cnt}, 8'h01, "sample");
    if (k == 3000) begin
      err_count++;
      $display("wrong value at %0t: no end", $time);
      give_verdict();
    end
  endtask
  // ============================================================
  // Tests
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 8'hf2; a < 8'hfa; a++) rd(a[7:0], 8'h00);
    $display("end reset");
    wr(8'hf6, 8'hfe);
    rd(8'hf6, 8'hfe);
    chk(pin, 8'hfe, "pins");
    wr(8'hf2, 8'h1f);
    rd(8'hf2, 8'h1f);
    wr(8'hf8, 8'h03);
    wr(8'hf3, 8'h28);
    rd(8'hf3, 8'h20);
    chk({7'h0, irq}, 8'h01, "irq");
    wr(8'hf7, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h00, "irq");
    @(posedge clk);
    $display("end refused");
    wr(8'hf6, 8'hff);
    wr(8'hf2, 8'h01);
    for (int ch = 0; ch < 8; ch++) begin
      c = 8'h28 | ch[7:0] | (ch == 7 ? 8'h40 : 8'h00);
      run(c, n, q);
      if (ch == 0) base = n;
      res = {ch[2:0], 4'h9, ch[2:0]};
      chk({7'h0, n == base && n > 20 && n < 26}, 8'h01, "len");
      chk({7'h0, q == (ch == 7 ? n : 0)}, 8'h01, "quiet");
      chk({7'h0, on}, 8'h01, "on");
      chk({5'h0, chan}, ch[7:0], "chan");
      chk({7'h0, irq}, 8'h01, "irq");
      rd(8'hf3, c ^ 8'h18);
      wr(8'hf5, 8'hff);
      wr(8'hf4, 8'hff);
      rd(8'hf5, res[9:2]);
      rd(8'hf4, {6'h0, res[1:0]});
      wr(8'hf3, c & 8'he7);
      rd(8'hf3, c & 8'he7);
      wr(8'hf7, 8'h01);
      #1;
      chk({7'h0, irq}, 8'h00, "irq");
      @(posedge clk);
    end
    $display("end channels");
    wr(8'hf2, 8'h03);
    run(8'h28, m, q);
    chk({7'h0, m - base == 44}, 8'h01, "div");
    wr(8'hf2, 8'h00);
    run(8'h28, m, q);
    chk({7'h0, m - base == 682}, 8'h01, "div");
    chk({7'h0, q == 0}, 8'h01, "quiet");
    chk({7'h0, irq}, 8'h01, "irq");
    // Done status stays set here, so a cleared mask bit alone must drop the line
    wr(8'hf8, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h00, "irq");
    @(posedge clk);
    wr(8'hf3, 8'h20);
    wr(8'hf7, 8'h01);
    $display("end divider");
    wr(8'hf2, 8'h01);
    wr(8'hf3, 8'h29);
    repeat (10) @(posedge clk);
    wr(8'hf3, 8'h00);
    rd(8'hf3, 8'h00);
    chk({7'h0, on}, 8'h00, "on");
    chk({7'h0, conv}, 8'h00, "conv");
    rd(8'hf7, 8'h00);
    rd(8'hf5, 8'h12);
    $display("end abort");
    give_verdict();
  end
endmodule // adc_register_control_tb
`default_nettype wire

// >>> dv/adcrc_chk.sv
// Port-level assertions for the ADC register control block
`default_nettype none
module adcrc_chk (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic [7:0] O_PIN_ANALOG,
  input wire logic [2:0] O_CHANNEL,
  input wire logic O_CONVERTER_ON,
  input wire logic O_SAMPLE_HOLD,
  input wire logic O_CONVERTING,
  input wire logic O_QUIET_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read slot");
  pin_hold_a: assert property (!$past(I_WR) && !$past(I_WR, 2) |-> $stable(O_PIN_ANALOG))
    else $error("pin select moved without write");
  sh_first_a: assert property ($rose(O_CONVERTING) |-> O_SAMPLE_HOLD)
    else $error("conversion did not open with sample");
  sh_len_a: assert property ($rose(O_SAMPLE_HOLD) |-> O_SAMPLE_HOLD [*2])
    else $error("sample period too short");
  conv_min_a: assert property ($rose(O_CONVERTING) && O_CONVERTER_ON |-> O_CONVERTING [*8])
    else $error("conversion ended too early");
  chan_hold_a: assert property (O_CONVERTING && $past(O_CONVERTING) |-> $stable(O_CHANNEL))
    else $error("channel moved during conversion");
  quiet_conv_a: assert property (O_QUIET_ACTIVE || O_SAMPLE_HOLD |-> O_CONVERTING)
    else $error("quiet or sample outside conversion");
  abort_stop_a: assert property ($fell(O_CONVERTER_ON) |-> ##[0:2] !O_CONVERTING)
    else $error("conversion kept running when off");
endmodule // adcrc_chk
bind adcrc_top adcrc_chk adcrc_chk_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_PIN_ANALOG(O_PIN_ANALOG), .O_CHANNEL(O_CHANNEL),
  .O_CONVERTER_ON(O_CONVERTER_ON), .O_SAMPLE_HOLD(O_SAMPLE_HOLD),
  .O_CONVERTING(O_CONVERTING), .O_QUIET_ACTIVE(O_QUIET_ACTIVE));
`default_nettype wire

// >>> dv/adcrc_core_model.sv
// Behavioural analog core: gives a code built from the channel it converts
`default_nettype none
module adcrc_core_model (
  input wire logic I_CLK,
  input wire logic [2:0] i_channel,
  input wire logic i_converting,
  output logic [9:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_result = 10'h2aa;
  // Idle code flips every cycle so a result latched outside a conversion shows
  always @(posedge I_CLK) begin
    if (i_converting) begin
      o_result <= {i_channel, 4'h9, i_channel};
    end else begin
      o_result <= ~o_result;
    end
  end
endmodule // adcrc_core_model
`default_nettype wire
